// ==== hw/alu_pkg.sv ====
package alu_pkg;

  // Operation codes issued by the instruction decoder
  typedef enum logic [3:0] {
    op_add                    = 4'h0,
    op_add_carry              = 4'h1,
    op_word_immediate_increase = 4'h2,
    op_difference             = 4'h3,
    op_immediate_difference   = 4'h4,
    op_difference_with_borrow = 4'h5,
    op_immediate_difference_with_borrow = 4'h6,
    op_word_immediate_decrease = 4'h7,
    op_conjunction            = 4'h8,
    op_immediate_conjunction  = 4'h9,
    op_union                  = 4'ha,
    op_immediate_union        = 4'hb,
    op_bitwise_exclusive_union = 4'hc,
    op_set_mask_bits          = 4'hd,
    op_clear_mask_bits        = 4'he,
    op_zero_sign_test         = 4'hf
  } alu_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    st_idle      = 2'b01,
    st_word_high = 2'b10
  } alu_state_t;

  // Status flag bit positions
  localparam int unsigned FLAG_W            = 6;
  localparam int unsigned FLAG_WRAPAROUND   = 0;
  localparam int unsigned FLAG_RESULT_NULL  = 1;
  localparam int unsigned FLAG_TOP_BIT      = 2;
  localparam int unsigned FLAG_SIGNED_WRAP  = 3;
  localparam int unsigned FLAG_TRUE_POLARITY = 4;
  localparam int unsigned FLAG_NIBBLE_CARRY = 5;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned MSB      = 7;
  localparam int unsigned NIB_MSB  = 3;

  localparam logic [7:0]        BYTE_ZERO  = 8'h00;
  localparam logic [7:0]        BYTE_ONES  = 8'hff;
  localparam logic [FLAG_W-1:0] FLAGS_RST  = 6'h00;

endpackage : alu_pkg

// ==== hw/byte_adder.sv ====
`timescale 1ns/10ps

// Eight-bit adder and subtractor with carry or borrow in and status terms out
module byte_adder
  import alu_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       cin_i,
  input  wire logic       sub_i,
  output logic      [7:0] sum_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            ovf_o
);

  logic [8:0] full;
  logic [4:0] nib;

  // Sum or difference; bit 8 is carry or borrow
  always_comb
  begin
    if (sub_i)
    begin
      full = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
      nib  = {1'b0, a_i[NIB_MSB:0]} - {1'b0, b_i[NIB_MSB:0]} - {4'h0, cin_i};
    end
    else
    begin
      full = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
      nib  = {1'b0, a_i[NIB_MSB:0]} + {1'b0, b_i[NIB_MSB:0]} + {4'h0, cin_i};
    end
  end

  // Result, carry from bit 8, half carry from the low nibble; overflow from the operand and result sign bits
  always_comb
  begin
    sum_o   = full[MSB:0];
    carry_o = full[DATA_W];
    half_o  = nib[NIB_MSB+1];
    if (sub_i)
      ovf_o = (a_i[MSB] & ~b_i[MSB] & ~full[MSB]) | (~a_i[MSB] & b_i[MSB] & full[MSB]);
    else
      ovf_o = (a_i[MSB] & b_i[MSB] & ~full[MSB]) | (~a_i[MSB] & ~b_i[MSB] & full[MSB]);
  end

endmodule : byte_adder

// ==== hw/integer_arith_logic_unit.sv ====
`timescale 1ns/10ps

module integer_arith_logic_unit
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        start_i,
  input  wire alu_pkg::alu_op_t            op_i,
  input  wire logic [7:0]                  dst_i,
  input  wire logic [7:0]                  dst_hi_i,
  input  wire logic [7:0]                  src_i,
  input  wire logic [7:0]                  imm_i,
  input  wire logic                        flags_load_i,
  input  wire logic [alu_pkg::FLAG_W-1:0]  flags_i,
  output logic      [7:0]                  result_lo_o,
  output logic      [7:0]                  result_hi_o,
  output logic                             write_byte_o,
  output logic                             write_pair_o,
  output logic      [alu_pkg::FLAG_W-1:0]  flags_o,
  output logic                             busy_o
);

  import alu_pkg::*;

  alu_state_t        state_ff;
  alu_state_t        nxt_state;
  logic [7:0]        result_lo_ff;
  logic [7:0]        result_hi_ff;
  logic              write_byte_ff;
  logic              write_pair_ff;
  logic              busy_ff;
  logic [FLAG_W-1:0] flags_ff;
  logic [FLAG_W-1:0] nxt_flags;
  logic [7:0]        hi_held_ff;
  logic [7:0]        lo_held_ff;
  logic              carry_held_ff;
  logic              dec_held_ff;

  logic              accept;
  logic [7:0]        add_a;
  logic [7:0]        add_b;
  logic              add_cin;
  logic              add_sub;
  logic [7:0]        add_sum;
  logic              add_carry;
  logic              add_half;
  logic              add_ovf;
  logic [7:0]        logic_res;
  logic              is_arith;
  logic              is_word;
  logic              word_top;
  logic              word_ovf;
  logic              word_wrap;

  // A new operation is taken only when no word operation is in flight
  assign accept = start_i & (state_ff == st_idle);

  // Shared adder; the high half of a word operation reuses it
  byte_adder byte_adder_i
  (
    .a_i     (add_a),
    .b_i     (add_b),
    .cin_i   (add_cin),
    .sub_i   (add_sub),
    .sum_o   (add_sum),
    .carry_o (add_carry),
    .half_o  (add_half),
    .ovf_o   (add_ovf)
  );

  // Operand selection for the adder
  always_comb
  begin
    add_a    = dst_i;
    add_b    = src_i;
    add_cin  = 1'b0;
    add_sub  = 1'b0;
    is_arith = 1'b1;
    is_word  = 1'b0;
    if (state_ff == st_word_high)
    begin
      add_a   = hi_held_ff;
      add_b   = BYTE_ZERO;
      add_cin = carry_held_ff;
      add_sub = dec_held_ff;
    end
    else
    begin
      case (op_i)
        op_add: ;
        op_add_carry: add_cin = flags_ff[FLAG_WRAPAROUND];
        op_word_immediate_increase:
        begin
          add_b   = imm_i;
          is_word = 1'b1;
        end
        op_difference: add_sub = 1'b1;
        op_immediate_difference:
        begin
          add_b   = imm_i;
          add_sub = 1'b1;
        end
        op_difference_with_borrow:
        begin
          add_sub = 1'b1;
          add_cin = flags_ff[FLAG_WRAPAROUND];
        end
        op_immediate_difference_with_borrow:
        begin
          add_b   = imm_i;
          add_sub = 1'b1;
          add_cin = flags_ff[FLAG_WRAPAROUND];
        end
        op_word_immediate_decrease:
        begin
          add_b   = imm_i;
          add_sub = 1'b1;
          is_word = 1'b1;
        end
        default: is_arith = 1'b0;
      endcase
    end
  end

  // Bitwise results
  always_comb
  begin
    case (op_i)
      op_conjunction:             logic_res = dst_i & src_i;
      op_immediate_conjunction:   logic_res = dst_i & imm_i;
      op_union:                   logic_res = dst_i | src_i;
      op_immediate_union:         logic_res = dst_i | imm_i;
      op_bitwise_exclusive_union: logic_res = dst_i ^ src_i;
      op_set_mask_bits:           logic_res = dst_i | imm_i;
      op_clear_mask_bits:         logic_res = dst_i & (BYTE_ONES - imm_i);
      op_zero_sign_test:          logic_res = dst_i & dst_i;
      default:                    logic_res = dst_i;
    endcase
  end

  // Word status terms from the held high byte and the new high byte
  always_comb
  begin
    word_top = add_sum[MSB];
    if (dec_held_ff)
    begin
      word_ovf  = hi_held_ff[MSB] & ~add_sum[MSB];
      word_wrap = add_sum[MSB] & ~hi_held_ff[MSB];
    end
    else
    begin
      word_ovf  = ~hi_held_ff[MSB] & add_sum[MSB];
      word_wrap = ~add_sum[MSB] & hi_held_ff[MSB];
    end
  end

  // Next flag values; untouched flags keep their value
  always_comb
  begin
    nxt_flags = flags_ff;
    if (state_ff == st_word_high)
    begin
      nxt_flags[FLAG_RESULT_NULL]   = ({add_sum, lo_held_ff} == {BYTE_ZERO, BYTE_ZERO});
      nxt_flags[FLAG_WRAPAROUND]    = word_wrap;
      nxt_flags[FLAG_TOP_BIT]       = word_top;
      nxt_flags[FLAG_SIGNED_WRAP]   = word_ovf;
      nxt_flags[FLAG_TRUE_POLARITY] = word_top ^ word_ovf;
    end
    else if (accept & is_arith & ~is_word)
    begin
      nxt_flags[FLAG_RESULT_NULL]  = (add_sum == BYTE_ZERO);
      nxt_flags[FLAG_WRAPAROUND]   = add_carry;
      nxt_flags[FLAG_TOP_BIT]      = add_sum[MSB];
      nxt_flags[FLAG_SIGNED_WRAP]  = add_ovf;
      nxt_flags[FLAG_NIBBLE_CARRY] = add_half;
    end
    else if (accept & ~is_arith)
    begin
      nxt_flags[FLAG_RESULT_NULL] = (logic_res == BYTE_ZERO);
      nxt_flags[FLAG_TOP_BIT]     = logic_res[MSB];
      nxt_flags[FLAG_SIGNED_WRAP] = 1'b0;
    end
    else if (flags_load_i & ~accept)
    begin
      nxt_flags = flags_i;
    end
  end

  // Sequencer: word operations take a second cycle for the high byte
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle:      if (accept & is_word) nxt_state = st_word_high;
      st_word_high: nxt_state = st_idle;
      default:      nxt_state = st_idle;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_ff <= st_idle;
    else
      state_ff <= nxt_state;
  end

  // Status flags
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      flags_ff <= FLAGS_RST;
    else
      flags_ff <= nxt_flags;
  end

  // Low byte and carry held between the two word cycles
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hi_held_ff    <= BYTE_ZERO;
      lo_held_ff    <= BYTE_ZERO;
      carry_held_ff <= 1'b0;
      dec_held_ff   <= 1'b0;
    end
    else if (accept & is_word)
    begin
      hi_held_ff    <= dst_hi_i;
      lo_held_ff    <= add_sum;
      carry_held_ff <= add_carry;
      dec_held_ff   <= add_sub;
    end
  end

  // Results and write strobes toward the register file
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_lo_ff  <= BYTE_ZERO;
      result_hi_ff  <= BYTE_ZERO;
      write_byte_ff <= 1'b0;
      write_pair_ff <= 1'b0;
    end
    else if (state_ff == st_word_high)
    begin
      result_lo_ff  <= lo_held_ff;
      result_hi_ff  <= add_sum;
      write_byte_ff <= 1'b0;
      write_pair_ff <= 1'b1;
    end
    else if (accept & ~is_word)
    begin
      result_lo_ff  <= is_arith ? add_sum : logic_res;
      result_hi_ff  <= BYTE_ZERO;
      write_byte_ff <= 1'b1;
      write_pair_ff <= 1'b0;
    end
    else
    begin
      write_byte_ff <= 1'b0;
      write_pair_ff <= 1'b0;
    end
  end

  // Busy while the high byte of a word operation is pending
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_state == st_word_high);
  end

  assign result_lo_o  = result_lo_ff;
  assign result_hi_o  = result_hi_ff;
  assign write_byte_o = write_byte_ff;
  assign write_pair_o = write_pair_ff;
  assign flags_o      = flags_ff;
  assign busy_o       = busy_ff;

endmodule : integer_arith_logic_unit

// ==== test/alu_checker_sva.sv ====
`timescale 1ns/10ps

// Timing and value checks at the unit's ports
module alu_checker
  import alu_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       reset_i,
  input wire logic                       start_i,
  input wire alu_pkg::alu_op_t           op_i,
  input wire logic [7:0]                 dst_i,
  input wire logic [7:0]                 dst_hi_i,
  input wire logic [7:0]                 src_i,
  input wire logic [7:0]                 imm_i,
  input wire logic                       flags_load_i,
  input wire logic [alu_pkg::FLAG_W-1:0] flags_i,
  input wire logic [7:0]                 result_lo_o,
  input wire logic [7:0]                 result_hi_o,
  input wire logic                       write_byte_o,
  input wire logic                       write_pair_o,
  input wire logic [alu_pkg::FLAG_W-1:0] flags_o,
  input wire logic                       busy_o
);
  logic take;
  logic word;

  // An operation is taken only while idle
  assign take = start_i && !busy_o;
  assign word = op_i inside {op_word_immediate_increase, op_word_immediate_decrease};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_byte_one_cycle: assert property (take && !word |=> write_byte_o && !write_pair_o)
    else $error("byte op strobe missing");
  a_word_two_cycles: assert property (take && word |=> busy_o && !write_pair_o ##1 write_pair_o && !busy_o)
    else $error("word op timing wrong");
  a_carry_sum_value: assert property (take && op_i == op_add_carry |=>
    result_lo_o == $past(dst_i) + $past(src_i) + $past(flags_o[0]))
    else $error("carry sum wrong");
  a_imm_diff_value: assert property (take && op_i == op_immediate_difference |=>
    result_lo_o == $past(dst_i) - $past(imm_i))
    else $error("constant difference wrong");
  a_borrow_diff_value: assert property (take && op_i == op_difference_with_borrow |=>
    result_lo_o == $past(dst_i) - $past(src_i) - $past(flags_o[0]))
    else $error("borrow difference wrong");
  a_word_dec_value: assert property (take && op_i == op_word_immediate_decrease |=> ##1
    {result_hi_o, result_lo_o} == {$past(dst_hi_i, 2), $past(dst_i, 2)} - $past(imm_i, 2))
    else $error("word decrease wrong");
  a_mask_clear_value: assert property (take && op_i == op_clear_mask_bits |=>
    result_lo_o == ($past(dst_i) & ~$past(imm_i)) && !flags_o[FLAG_SIGNED_WRAP])
    else $error("mask clear wrong");
  a_test_keeps_value: assert property (take && op_i == op_zero_sign_test |=>
    result_lo_o == $past(dst_i) && flags_o[FLAG_RESULT_NULL] == (result_lo_o == 8'h00))
    else $error("zero-sign test wrong");
  a_logic_keeps_flags: assert property (take && op_i[3] |=>
    {flags_o[5:4], flags_o[0]} == {$past(flags_o[5:4]), $past(flags_o[0])})
    else $error("unlisted flag moved");
endmodule : alu_checker

bind integer_arith_logic_unit alu_checker alu_checker_i (.clk_i(clk_i), .reset_i(reset_i),
  .start_i(start_i), .op_i(op_i), .dst_i(dst_i), .dst_hi_i(dst_hi_i), .src_i(src_i),
  .imm_i(imm_i), .flags_load_i(flags_load_i), .flags_i(flags_i), .result_lo_o(result_lo_o),
  .result_hi_o(result_hi_o), .write_byte_o(write_byte_o), .write_pair_o(write_pair_o),
  .flags_o(flags_o), .busy_o(busy_o));

// ==== test/integer_arith_logic_unit_tb.sv ====
`timescale 1ns/10ps

// Self-checking bench for the arithmetic and logic unit
module integer_arith_logic_unit_tb;
  import alu_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        start_i, flags_load_i, write_byte_o, write_pair_o, busy_o, note, done;
  alu_op_t     op_i;
  logic [7:0]  dst_i, dst_hi_i, src_i, imm_i, result_lo_o, result_hi_o;
  logic [5:0]  flags_i, flags_o;
  logic [22:0] note_data;
  logic [22:0] e;
  logic [22:0] notes[$];
  int          fails = 0;
  int          samples_checked = 0;
  int          i;

  always #10 clk_i = ~clk_i;

  integer_arith_logic_unit integer_arith_logic_unit_i (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(start_i), .op_i(op_i), .dst_i(dst_i), .dst_hi_i(dst_hi_i), .src_i(src_i),
    .imm_i(imm_i), .flags_load_i(flags_load_i), .flags_i(flags_i), .result_lo_o(result_lo_o),
    .result_hi_o(result_hi_o), .write_byte_o(write_byte_o), .write_pair_o(write_pair_o),
    .flags_o(flags_o), .busy_o(busy_o));

  op_source op_source_i (.clk_i(clk_i), .start_o(start_i), .op_o(op_i), .dst_o(dst_i),
    .dst_hi_o(dst_hi_i), .src_o(src_i), .imm_o(imm_i), .load_o(flags_load_i),
    .load_value_o(flags_i), .note_o(note), .note_data_o(note_data), .done_o(done));

  task automatic check(input string what, input logic [22:0] exp, input logic [22:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Records the request taken at this edge, then pairs each strobe with the oldest note
  always @(posedge clk_i)
  begin
    #1;
    if (note === 1'b1 && reset_i === 1'b0)
      notes.push_back(note_data);
    if (write_byte_o !== 1'b0 || write_pair_o !== 1'b0)
    begin
      if (notes.size() == 0)
        check("unexpected strobe", 23'h0, 23'h1);
      else
      begin
        e = notes.pop_front();
        check("pair strobe", e[22], write_pair_o);
        check("result", e[21:6], {result_hi_o, result_lo_o});
        check("flags", e[5:0], flags_o);
      end
    end
  end

  // Reset, bounded wait for the traffic to end, final drain check
  initial
  begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    for (i = 0; i < 5000 && done !== 1'b1; i++)
      @(posedge clk_i);
    if (done !== 1'b1)
      fails++;
    repeat (4) @(posedge clk_i);
    check("leftover notes", 23'h0, 23'(notes.size()));
    finish_test();
  end
endmodule : integer_arith_logic_unit_tb

// ==== test/op_source.sv ====
`timescale 1ns/10ps

// Decoder and register file stand-in: issues random operations and notes results
module op_source
  import alu_pkg::*;
(
  input  wire logic        clk_i,
  output logic             start_o,
  output alu_pkg::alu_op_t op_o,
  output logic [7:0]       dst_o,
  output logic [7:0]       dst_hi_o,
  output logic [7:0]       src_o,
  output logic [7:0]       imm_o,
  output logic             load_o,
  output logic [5:0]       load_value_o,
  output logic             note_o,
  output logic [22:0]      note_data_o,
  output logic             done_o
);
  logic [5:0]  fl;
  logic [22:0] e;

  // Expected {pair, high, low, flags} of one operation
  function automatic logic [22:0] ref_op(alu_op_t op, logic [7:0] d, h, s, k, logic [5:0] f);
    logic [16:0] w;
    logic [8:0]  r;
    logic [4:0]  n;
    logic [7:0]  b;
    logic        c;
    logic        sb;
    b = (op inside {op_add, op_add_carry, op_difference, op_difference_with_borrow,
      op_conjunction, op_union, op_bitwise_exclusive_union}) ? s : k;
    c = f[0] && (op inside {op_add_carry, op_difference_with_borrow,
      op_immediate_difference_with_borrow});
    sb = op inside {op_difference, op_immediate_difference, op_difference_with_borrow,
      op_immediate_difference_with_borrow};
    case (op)
      op_word_immediate_increase, op_word_immediate_decrease:
      begin
        sb = op == op_word_immediate_decrease;
        w = sb ? {1'b0, h, d} - k : {1'b0, h, d} + k;
        f[3:0] = {(h[7] ^ ~sb) & (h[7] ^ w[15]), w[15], w[15:0] == 16'h0000, w[16]};
        f[4] = f[2] ^ f[3];
        return {1'b1, w[15:0], f};
      end
      op_add, op_add_carry, op_difference, op_immediate_difference,
      op_difference_with_borrow, op_immediate_difference_with_borrow:
      begin
        r = sb ? {1'b0, d} - b - c : {1'b0, d} + b + c;
        n = sb ? {1'b0, d[3:0]} - b[3:0] - c : {1'b0, d[3:0]} + b[3:0] + c;
        f[5] = n[4];
        f[3:0] = {(d[7] ^ b[7] ^ ~sb) & (r[7] ^ d[7]), r[7], r[7:0] == 8'h00, r[8]};
        return {9'h000, r[7:0], f};
      end
      default:
      begin
        case (op)
          op_conjunction, op_immediate_conjunction: r[7:0] = d & b;
          op_clear_mask_bits: r[7:0] = d & (BYTE_ONES - k);
          op_zero_sign_test: r[7:0] = d & d;
          op_bitwise_exclusive_union: r[7:0] = d ^ b;
          default: r[7:0] = d | b;
        endcase
        f[3:1] = {1'b0, r[7], r[7:0] == 8'h00};
        return {9'h000, r[7:0], f};
      end
    endcase
  endfunction : ref_op

  assign note_data_o = e;

  // Random mix of operations, flag loads and idle cycles
  initial
  begin
    {start_o, op_o, dst_o, dst_hi_o, src_o, imm_o, load_o, load_value_o, note_o, done_o} = '0;
    e = '0;
    fl = FLAGS_RST;
    void'($urandom(32'hbbc5));
    repeat (4) @(negedge clk_i);
    repeat (600)
    begin
      {dst_o, dst_hi_o, src_o, imm_o} = $urandom;
      op_o = alu_op_t'(4'($urandom));
      load_value_o = 6'($urandom);
      load_o = 1'($urandom);
      start_o = ($urandom % 4) != 0;
      note_o = start_o;
      e = ref_op(op_o, dst_o, dst_hi_o, src_o, imm_o, fl);
      if (start_o)
        fl = e[5:0];
      else if (load_o)
        fl = load_value_o;
      @(negedge clk_i);
      if (start_o && e[22])
      begin
        // Request and load in the busy cycle must both be ignored
        op_o = alu_op_t'(4'($urandom));
        load_o = 1'b1;
        load_value_o = ~fl;
        note_o = 1'b0;
        @(negedge clk_i);
      end
    end
    {start_o, load_o, note_o} = '0;
    done_o = 1'b1;
  end
endmodule : op_source
